//--- rtl/mhb_pkg.sv
package mhb_pkg;

    // Host phase timing; least times round up to whole 8 ns cycles.
    localparam int CLK_PERIOD_NS = 8;
    localparam int STROBE_NS     = 64;
    localparam int HOLD_NS       = 32;
    localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC      = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);
    localparam logic [3:0] PHASE_LAST  = 4'(STROBE_CYC + HOLD_CYC - 1);

    // Pieces that make one 32-bit word, and reset values.
    localparam logic [2:0]  PIECES_WIDE   = 3'h2;
    localparam logic [2:0]  PIECES_NARROW = 3'h4;
    localparam logic [15:0] ADDR_RST      = 16'h0000;
    localparam logic [31:0] WORD_RST      = 32'h0000_0000;
    localparam logic [7:0]  LANE_IDLE     = 8'h00;

    // Port configuration; a polarity bit gives the active pin level.
    typedef struct packed {
        logic ale_pol;
        logic cs_pol;
        logic rd_pol;
        logic wr_pol;
        logic dir_style;
        logic ale_qual;
        logic dual_phase;
        logic width16;
    } mhb_cfg_type;

    // Host byte index to internal little-endian byte index.
    function automatic logic [1:0] mhb_byte_map(input logic [1:0] host_byte,
                                                input logic       big);
        mhb_byte_map = big ? ~host_byte : host_byte;
    endfunction

endpackage

//--- rtl/mhb_bus_if.sv
`timescale 1ns/100ps
`default_nettype none
interface mhb_bus_if;

    logic        ale_lo;
    logic        ale_hi;
    logic        cs;
    logic        rd_dir;
    logic        wr_xfer;
    logic        endian_sel;
    logic [15:0] host_ad;
    logic [1:0]  host_ad_oe;
    logic [15:0] dev_ad;
    logic [1:0]  dev_ad_oe;
    logic [15:0] ad_level;

    // Each byte lane resolves from its drivers; an undriven lane reads as idle.
    for (genvar l = 0; l < 2; l++) begin : g_res
        assign ad_level[8*l +: 8] = host_ad_oe[l] ? host_ad[8*l +: 8] :
                                    dev_ad_oe[l] ? dev_ad[8*l +: 8] : mhb_pkg::LANE_IDLE;
    end

    modport device (input ale_lo, ale_hi, cs, rd_dir, wr_xfer, endian_sel, ad_level,
                    output dev_ad, dev_ad_oe);
    modport host (output ale_lo, ale_hi, cs, rd_dir, wr_xfer, endian_sel, host_ad,
                  host_ad_oe, input ad_level);

endinterface
`default_nettype wire

//--- rtl/mhb_device_end.sv
`timescale 1ns/100ps
`default_nettype none
module mhb_device_end (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire mhb_pkg::mhb_cfg_type cfg,
    mhb_bus_if.device                 bus,
    input  wire logic [31:0]          reg_rdata,
    output logic [15:0]               reg_addr,
    output logic [31:0]               reg_wdata,
    output logic                      reg_wr_stb,
    output logic                      reg_rd_stb
);
    import mhb_pkg::*;

    // Pin capture and edge history; none of these flops needs a reset.
    logic [5:0]  ctl_meta_reg;
    logic [5:0]  ctl_sync_reg;
    logic [15:0] ad_meta_reg;
    logic [15:0] ad_sync_reg;
    logic [3:0]  act_prev_reg;
    // Latched address, endianness, word assembly and read snapshot.
    logic [15:0] addr_reg;
    logic [15:0] addr_next;
    logic        big_reg;
    logic        big_next;
    logic [31:0] asm_reg;
    logic [31:0] asm_next;
    logic [31:0] rd_hold_reg;
    // Piece counters, read drive and the internal access strobes.
    logic [2:0]  wr_cnt_reg;
    logic [2:0]  rd_cnt_reg;
    logic [15:0] dev_ad_reg;
    logic [1:0]  dev_oe_reg;
    logic [31:0] wdata_reg;
    logic        wr_stb_reg;
    logic        rd_stb_reg;
    // Per-lane decode results, one entry for each byte lane of the bus.
    logic [1:0]  lane_byte [2];
    logic [7:0]  lane_rd [2];

    // Two flops on every pin before any decode; the pins are asynchronous.
    // Lanes and control pins pass the same depth, so a strobe edge and the
    // bus value that it qualifies reach the decode in the same cycle.
    // These carry no reset, so rst must be held long enough to flush them.
    always_ff @(posedge clock) begin
        ctl_meta_reg <= {bus.endian_sel, bus.wr_xfer, bus.rd_dir, bus.cs, bus.ale_hi,
                         bus.ale_lo};
        ctl_sync_reg <= ctl_meta_reg;
        ad_meta_reg  <= bus.ad_level;
        ad_sync_reg  <= ad_meta_reg;
    end

    // Active levels after polarity; the strobe set follows the control style.
    // In the direction style the transfer strobe times the cycle and rd_dir only
    // says which way it goes, so rd_dir may change while the strobe is idle.
    wire cs_act = (ctl_sync_reg[2] == cfg.cs_pol);
    wire ale_ok = !cfg.ale_qual || cs_act;
    wire lo_act = (ctl_sync_reg[0] == cfg.ale_pol) && ale_ok;
    wire hi_act = (ctl_sync_reg[1] == cfg.ale_pol) && ale_ok;
    wire rd_lvl = (ctl_sync_reg[3] == cfg.rd_pol);
    wire wr_lvl = (ctl_sync_reg[4] == cfg.wr_pol);
    wire rd_act = cs_act && (cfg.dir_style ? (wr_lvl && rd_lvl) : rd_lvl);
    wire wr_act = cs_act && (cfg.dir_style ? (wr_lvl && !rd_lvl) : wr_lvl);

    // Edge detection history; tracked during reset so no false edge follows it.
    // The history follows the live pins, so the first cycle after reset
    // compares like with like even when the polarities have just changed.
    always_ff @(posedge clock) begin
        act_prev_reg <= {wr_act, rd_act, hi_act, lo_act};
    end

    // Trailing edges end a phase; a read also starts at its leading edge.
    wire lo_end   = act_prev_reg[0] && !lo_act;
    wire hi_end   = act_prev_reg[1] && !hi_act;
    wire rd_begin = rd_act && !act_prev_reg[2];
    wire rd_end   = act_prev_reg[2] && !rd_act;
    wire wr_end   = act_prev_reg[3] && !wr_act;

    // Address latch; a phase that is skipped leaves its part untouched.
    // The high strobe is ignored in single phase, where one strobe carries the
    // whole address on both lanes.
    always_comb begin
        addr_next = addr_reg;
        big_next  = big_reg;
        if (lo_end) begin
            big_next = ctl_sync_reg[5];
            if (cfg.dual_phase) begin
                addr_next[7:0] = ad_sync_reg[7:0];
            end else begin
                addr_next = ad_sync_reg;
            end
        end
        if (hi_end && cfg.dual_phase) begin
            big_next        = ctl_sync_reg[5];
            addr_next[15:8] = ad_sync_reg[7:0];
        end
    end

    // Piece position and lane use; the narrow mode uses lanes 15:8 only for a single phase address.
    // A halfword piece always starts on an even byte, so bit 0 is forced low.
    wire [1:0] piece_base = cfg.width16 ? {addr_reg[1], 1'b0} : addr_reg[1:0];
    wire [1:0] lane_used  = {cfg.width16, 1'b1};
    wire [2:0] pieces     = cfg.width16 ? PIECES_WIDE : PIECES_NARROW;

    // Live data is held at the first piece so all pieces show one snapshot.
    // The trade-off: a register polled one piece at a time refreshes once a word.
    wire [31:0] rd_hold_next = (rd_begin && rd_cnt_reg == 3'h0) ? reg_rdata : rd_hold_reg;

    // Per lane: host byte to internal byte, and the byte returned on a read.
    // Big endian mirrors the byte index within the word; the piece order stays.
    for (genvar j = 0; j < 2; j++) begin : g_lane
        assign lane_byte[j] = mhb_byte_map(piece_base | 2'(j), big_reg);
        assign lane_rd[j]   = rd_hold_next[8*lane_byte[j] +: 8];
    end

    // Word assembly; any piece may come first since position comes from address.
    // Bytes outside the current piece keep whatever they held before.
    always_comb begin
        asm_next = asm_reg;
        for (int l = 0; l < 2; l++) begin
            if (wr_end && lane_used[l]) begin
                asm_next[8*lane_byte[l] +: 8] = ad_sync_reg[8*l +: 8];
            end
        end
    end

    // Separate write and read piece counters; the last piece fires one access.
    // A repeated piece is counted like any other, which the host must avoid.
    // A piece that never arrives leaves the count open until a later one fills it.
    wire [2:0] wr_cnt_inc  = wr_cnt_reg + 3'h1;
    wire [2:0] rd_cnt_inc  = rd_cnt_reg + 3'h1;
    wire       wr_last     = wr_end && (wr_cnt_inc == pieces);
    wire       rd_last     = rd_end && (rd_cnt_inc == pieces);
    wire [2:0] wr_cnt_next = wr_last ? 3'h0 : (wr_end ? wr_cnt_inc : wr_cnt_reg);
    wire [2:0] rd_cnt_next = rd_last ? 3'h0 : (rd_end ? rd_cnt_inc : rd_cnt_reg);

    // Control state and the internal access strobes.
    // The word register copies the assembly only on the last piece, so
    // reg_wdata never shows a half-built word.
    always_ff @(posedge clock) begin
        if (rst) begin
            addr_reg    <= ADDR_RST;
            big_reg     <= 1'b0;
            asm_reg     <= WORD_RST;
            rd_hold_reg <= WORD_RST;
            wr_cnt_reg  <= 3'h0;
            rd_cnt_reg  <= 3'h0;
            wdata_reg   <= WORD_RST;
            wr_stb_reg  <= 1'b0;
            rd_stb_reg  <= 1'b0;
        end else begin
            addr_reg    <= addr_next;
            big_reg     <= big_next;
            asm_reg     <= asm_next;
            rd_hold_reg <= rd_hold_next;
            wr_cnt_reg  <= wr_cnt_next;
            rd_cnt_reg  <= rd_cnt_next;
            wr_stb_reg  <= wr_last;
            rd_stb_reg  <= rd_last;
            if (wr_last) begin
                wdata_reg <= asm_next;
            end
        end
    end

    // Read data drive; the upper lane stays off in the narrow mode because the
    // host may still be holding address there.
    always_ff @(posedge clock) begin
        if (rst) begin
            dev_ad_reg <= {LANE_IDLE, LANE_IDLE};
            dev_oe_reg <= 2'b00;
        end else begin
            dev_ad_reg <= rd_act ? {lane_rd[1], lane_rd[0]} : {LANE_IDLE, LANE_IDLE};
            dev_oe_reg <= rd_act ? lane_used : 2'b00;
        end
    end

    // The internal address is the word that holds the latched byte address.
    // The strobes are single-cycle pulses; the consumer must act on that edge.
    assign reg_addr      = {addr_reg[15:2], 2'b00};
    assign reg_wdata     = wdata_reg;
    assign reg_wr_stb    = wr_stb_reg;
    assign reg_rd_stb    = rd_stb_reg;
    assign bus.dev_ad    = dev_ad_reg;
    assign bus.dev_ad_oe = dev_oe_reg;

endmodule
`default_nettype wire

//--- rtl/mhb_host_end.sv
`timescale 1ns/100ps
`default_nettype none
module mhb_host_end (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire mhb_pkg::mhb_cfg_type cfg,
    mhb_bus_if.host                   bus,
    input  wire logic                 cmd_valid,
    output logic                      cmd_ready,
    input  wire logic                 cmd_write,
    input  wire logic                 cmd_single,
    input  wire logic                 cmd_skip_hi,
    input  wire logic                 cmd_skip_lo,
    input  wire logic                 cmd_big,
    input  wire logic [15:0]          cmd_addr,
    input  wire logic [31:0]          cmd_wdata,
    output logic                      rsp_valid,
    output logic [31:0]               rsp_rdata
);
    import mhb_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_AHI, H_ALO, H_DATA} mhb_host_state_type;

    mhb_host_state_type state_reg;
    mhb_host_state_type state_next;
    logic [3:0]  tmr_reg;
    logic [1:0]  piece_reg;
    logic [2:0]  left_reg;
    logic        wr_reg;
    logic        skip_lo_reg;
    logic        big_reg;
    logic [15:0] addr_reg;
    logic [31:0] wdata_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        rsp_reg;
    logic [15:0] ad_meta_reg;
    logic [15:0] ad_sync_reg;
    logic [4:0]  ctl_pin_reg;
    logic [15:0] ad_pin_reg;
    logic [1:0]  oe_pin_reg;
    logic [15:0] ad_next;
    logic [1:0]  oe_next;
    logic [1:0]  host_byte [2];
    logic [7:0]  wr_lane [2];

    // Phase timing: strobe active, then held inactive with the bus unchanged.
    wire       phase_end = (tmr_reg == PHASE_LAST);
    wire       strobe_on = (tmr_reg <= STROBE_LAST);
    wire [2:0] pieces    = cfg.width16 ? PIECES_WIDE : PIECES_NARROW;
    wire [1:0] step      = cfg.width16 ? 2'h2 : 2'h1;
    wire [2:0] left_dec  = left_reg - 3'h1;
    wire [15:0] cur      = {addr_reg[15:2], piece_reg};
    wire       take      = cmd_valid && (state_reg == H_IDLE);
    wire [1:0] first_pc  = cfg.width16 ? {cmd_addr[1], 1'b0} : cmd_addr[1:0];
    wire       in_data   = (state_reg == H_DATA);
    wire       sample    = in_data && !wr_reg && (tmr_reg == STROBE_LAST);

    // Sequencer; later pieces repeat only the low address phase, which carries the whole address in single phase.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            H_IDLE: begin
                if (take) begin
                    if (cfg.dual_phase && !cmd_skip_hi) begin
                        state_next = H_AHI;
                    end else if (!cmd_skip_lo) begin
                        state_next = H_ALO;
                    end else begin
                        state_next = H_DATA;
                    end
                end
            end
            H_AHI: begin
                if (phase_end) begin
                    state_next = skip_lo_reg ? H_DATA : H_ALO;
                end
            end
            H_ALO: begin
                if (phase_end) begin
                    state_next = H_DATA;
                end
            end
            H_DATA: begin
                if (phase_end) begin
                    if (left_dec == 3'h0) begin
                        state_next = H_IDLE;
                    end else begin
                        state_next = skip_lo_reg ? H_DATA : H_ALO;
                    end
                end
            end
        endcase
    end

    // Per lane: host byte of this piece, its write data and its read capture.
    for (genvar j = 0; j < 2; j++) begin : g_lane
        assign host_byte[j] = piece_reg | 2'(j);
        assign wr_lane[j]   = wdata_reg[8*host_byte[j] +: 8];
    end

    always_comb begin
        rdata_next = rdata_reg;
        for (int l = 0; l < 2; l++) begin
            if (sample && (l == 0 || cfg.width16)) begin
                rdata_next[8*host_byte[l] +: 8] = ad_sync_reg[8*l +: 8];
            end
        end
    end

    // Bus lanes per phase; address high travels on the low lane in dual phase, on the upper lane in single phase.
    always_comb begin
        ad_next = {LANE_IDLE, LANE_IDLE};
        oe_next = 2'b00;
        unique case (state_reg)
            H_AHI: begin
                ad_next = {LANE_IDLE, cur[15:8]};
                oe_next = 2'b01;
            end
            H_ALO: begin
                ad_next = cfg.dual_phase ? {LANE_IDLE, cur[7:0]} : cur;
                oe_next = cfg.dual_phase ? 2'b01 : 2'b11;
            end
            H_DATA: begin
                if (wr_reg) begin
                    ad_next = {wr_lane[1], wr_lane[0]};
                    oe_next = {cfg.width16, 1'b1};
                end
            end
            H_IDLE: begin
                oe_next = 2'b00;
            end
        endcase
    end

    // Strobe levels; a pin shows its polarity level while its strobe is active.
    wire rd_on  = in_data && strobe_on && !wr_reg;
    wire wr_on  = in_data && strobe_on && wr_reg;
    wire rd_pin = cfg.dir_style ? (!wr_reg ~^ cfg.rd_pol) : (rd_on ~^ cfg.rd_pol);
    wire wr_pin = (cfg.dir_style ? (rd_on || wr_on) : wr_on) ~^ cfg.wr_pol;
    wire hi_pin = ((state_reg == H_AHI) && strobe_on) ~^ cfg.ale_pol;
    wire lo_pin = ((state_reg == H_ALO) && strobe_on) ~^ cfg.ale_pol;
    wire cs_pin = (state_reg != H_IDLE) ~^ cfg.cs_pol;

    // Returned data is a pin input, so it passes two flops first.
    always_ff @(posedge clock) begin
        ad_meta_reg <= bus.ad_level;
        ad_sync_reg <= ad_meta_reg;
    end

    // Command state; a whole word walks its pieces inside one word address.
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg   <= H_IDLE;
            tmr_reg     <= 4'h0;
            piece_reg   <= 2'h0;
            left_reg    <= 3'h0;
            wr_reg      <= 1'b0;
            skip_lo_reg <= 1'b0;
            big_reg     <= 1'b0;
            addr_reg    <= ADDR_RST;
            wdata_reg   <= WORD_RST;
            rdata_reg   <= WORD_RST;
            rsp_reg     <= 1'b0;
        end else begin
            state_reg <= state_next;
            tmr_reg   <= (take || phase_end || state_reg == H_IDLE) ? 4'h0 : tmr_reg + 4'h1;
            rdata_reg <= rdata_next;
            rsp_reg   <= in_data && phase_end && !wr_reg && (left_dec == 3'h0);
            if (take) begin
                piece_reg   <= cmd_single ? first_pc : 2'h0;
                left_reg    <= cmd_single ? 3'h1 : pieces;
                wr_reg      <= cmd_write;
                skip_lo_reg <= cmd_skip_lo;
                big_reg     <= cmd_big;
                addr_reg    <= cmd_addr;
                wdata_reg   <= cmd_wdata;
            end else if (in_data && phase_end) begin
                piece_reg <= piece_reg + step;
                left_reg  <= left_dec;
            end
        end
    end

    // Pins leave flops; at reset every strobe shows its inactive level.
    always_ff @(posedge clock) begin
        if (rst) begin
            ctl_pin_reg <= {~cfg.rd_pol, ~cfg.wr_pol, ~cfg.cs_pol, ~cfg.ale_pol, ~cfg.ale_pol};
            ad_pin_reg  <= {LANE_IDLE, LANE_IDLE};
            oe_pin_reg  <= 2'b00;
        end else begin
            ctl_pin_reg <= {rd_pin, wr_pin, cs_pin, hi_pin, lo_pin};
            ad_pin_reg  <= ad_next;
            oe_pin_reg  <= oe_next;
        end
    end

    assign cmd_ready      = (state_reg == H_IDLE);
    assign rsp_valid      = rsp_reg;
    assign rsp_rdata      = rdata_reg;
    assign bus.ale_lo     = ctl_pin_reg[0];
    assign bus.ale_hi     = ctl_pin_reg[1];
    assign bus.cs         = ctl_pin_reg[2];
    assign bus.wr_xfer    = ctl_pin_reg[3];
    assign bus.rd_dir     = ctl_pin_reg[4];
    assign bus.endian_sel = big_reg;
    assign bus.host_ad    = ad_pin_reg;
    assign bus.host_ad_oe = oe_pin_reg;

endmodule
`default_nettype wire

//--- tb/mhb_bus_props.sv
`timescale 1ns/100ps
`default_nettype none
module mhb_bus_props (
    input wire logic                 clock,
    input wire logic                 rst,
    input wire mhb_pkg::mhb_cfg_type cfg,
    input wire logic                 ale_lo,
    input wire logic                 ale_hi,
    input wire logic                 cs,
    input wire logic                 rd_dir,
    input wire logic                 wr_xfer,
    input wire logic [1:0]           host_ad_oe,
    input wire logic [1:0]           dev_ad_oe,
    input wire logic                 reg_wr_stb
);
    import mhb_pkg::*;

    // Pin activity decoded for either control style and any polarity.
    wire logic sel_on  = (cs == cfg.cs_pol);
    wire logic dir_rd  = (rd_dir == cfg.rd_pol);
    wire logic xfer_on = (wr_xfer == cfg.wr_pol);
    wire logic rd_act  = sel_on && (cfg.dir_style ? (xfer_on && dir_rd) : dir_rd);
    wire logic wr_act  = sel_on && xfer_on && !(cfg.dir_style && dir_rd);
    wire logic ale_on  = (ale_lo == cfg.ale_pol) || (ale_hi == cfg.ale_pol);
    wire logic lo_on   = (ale_lo == cfg.ale_pol);

    // Short strobe histories; the synchroniser delay is not exact, so a small window is allowed.
    logic [7:0] rd_hist_reg;
    logic [7:0] wr_hist_reg;
    always_ff @(posedge clock) begin
        rd_hist_reg <= {rd_hist_reg[6:0], rd_act};
        wr_hist_reg <= {wr_hist_reg[6:0], wr_act};
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    no_fight_a: assert property ((host_ad_oe & dev_ad_oe) == 2'h0)
        else $error("both ends drive one lane");
    dev_upper_a: assert property (!cfg.width16 |-> !dev_ad_oe[1])
        else $error("device drives upper lane in narrow mode");
    host_upper_a: assert property (cfg.dual_phase && !cfg.width16 |-> !host_ad_oe[1])
        else $error("host drives upper lane in narrow dual mode");
    dual_addr_a: assert property (cfg.dual_phase && ale_on |-> !host_ad_oe[1])
        else $error("upper lane driven in dual address phase");
    single_addr_a: assert property (!cfg.dual_phase && lo_on |-> host_ad_oe == 2'h3)
        else $error("single phase address not on both lanes");
    read_quiet_a: assert property (rd_act |-> host_ad_oe == 2'h0)
        else $error("host drives lanes during read");
    read_drive_a: assert property ($rose(|dev_ad_oe) |-> rd_hist_reg[4:1] != 4'h0)
        else $error("device drives lanes without a read");
    write_timing_a: assert property (reg_wr_stb |->
        wr_hist_reg[6:2] != 5'h0 && !wr_hist_reg[0])
        else $error("word write not after a write trailing edge");
    wr_pulse_a: assert property (reg_wr_stb |=> !reg_wr_stb)
        else $error("word write strobe longer than one cycle");
endmodule
`default_nettype wire

//--- tb/mhb_tb.sv
`timescale 1ns/100ps
`default_nettype none
module mhb_tb;
    import mhb_pkg::*;

    logic        clock       = 1'b0;
    logic        rst         = 1'b1;
    mhb_cfg_type cfg         = mhb_cfg_type'(8'hF3);
    logic        cmd_valid   = 1'b0;
    logic        cmd_write   = 1'b0;
    logic        cmd_single  = 1'b0;
    logic        cmd_skip_hi = 1'b0;
    logic        cmd_skip_lo = 1'b0;
    logic        cmd_big     = 1'b0;
    logic [15:0] cmd_addr    = 16'h0000;
    logic [31:0] cmd_wdata   = 32'h0000_0000;
    logic        cmd_ready, rsp_valid, reg_wr_stb, reg_rd_stb;
    logic [31:0] rsp_rdata, reg_wdata, rsp_seen, wr_data;
    logic [15:0] reg_addr, wr_addr;
    logic [31:0] mem [0:15];
    int          num_errors  = 0;
    int          n_tests     = 0;
    int          wr_cnt      = 0;
    int          rd_cnt      = 0;
    wire logic [31:0] reg_rdata = mem[reg_addr[5:2]];

    always #4 clock = ~clock;

    mhb_bus_if mhb_bus_if_i ();
    mhb_host_end mhb_host_end_i (.clock(clock), .rst(rst), .cfg(cfg), .bus(mhb_bus_if_i),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
        .cmd_single(cmd_single), .cmd_skip_hi(cmd_skip_hi), .cmd_skip_lo(cmd_skip_lo),
        .cmd_big(cmd_big), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    mhb_device_end mhb_device_end_i (.clock(clock), .rst(rst), .cfg(cfg), .bus(mhb_bus_if_i),
        .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb));
    mhb_bus_props mhb_bus_props_i (.clock(clock), .rst(rst), .cfg(cfg),
        .ale_lo(mhb_bus_if_i.ale_lo), .ale_hi(mhb_bus_if_i.ale_hi), .cs(mhb_bus_if_i.cs),
        .rd_dir(mhb_bus_if_i.rd_dir), .wr_xfer(mhb_bus_if_i.wr_xfer),
        .host_ad_oe(mhb_bus_if_i.host_ad_oe), .dev_ad_oe(mhb_bus_if_i.dev_ad_oe),
        .reg_wr_stb(reg_wr_stb));

    // Word store behind the device; it also records every word access for the scenarios.
    always @(posedge clock) begin
        if (reg_wr_stb === 1'b1) begin
            mem[reg_addr[5:2]] <= reg_wdata;
            wr_cnt <= wr_cnt + 1;
            wr_addr <= reg_addr;
            wr_data <= reg_wdata;
        end
        if (reg_rd_stb === 1'b1) begin
            rd_cnt <= rd_cnt + 1;
        end
        if (rsp_valid === 1'b1) begin
            rsp_seen <= rsp_rdata;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // The configuration is static, so it only changes while reset is held.
    task automatic do_reset(input logic [7:0] c);
        @(posedge clock);
        cfg <= mhb_cfg_type'(c);
        rst <= 1'b1;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
    endtask

    task automatic run_cmd(input logic w, input logic sh, input logic sl, input logic bg,
                           input logic [15:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_skip_hi <= sh;
        cmd_skip_lo <= sl;
        cmd_big <= bg;
        cmd_addr <= a;
        cmd_wdata <= d;
        @(posedge clock);
        cmd_valid <= 1'b0;
        for (i = 0; i < 2000; i++) begin
            @(posedge clock);
            #1;
            if (cmd_ready === 1'b1) break;
        end
        chk(32'(i < 2000), 32'h1);
        // Leaves room for the word strobe, which trails the last piece by a few clocks.
        repeat (10) @(posedge clock);
    endtask

    task automatic write_read(input logic sh, input logic bg, input logic [15:0] a,
                              input logic [15:0] ea, input logic [31:0] d, input logic [31:0] di);
        int w0;
        int r0;
        w0 = wr_cnt;
        r0 = rd_cnt;
        run_cmd(1'b1, sh, 1'b0, bg, a, d);
        chk(32'(wr_cnt - w0), 32'h1);
        chk({16'h0000, wr_addr}, {16'h0000, ea});
        chk(wr_data, di);
        rsp_seen = 'x;
        run_cmd(1'b0, sh, 1'b0, bg, a, 32'h0000_0000);
        chk(rsp_seen, d);
        chk(32'(rd_cnt - r0), 32'h1);
    endtask

    task automatic sc_wide_dual();
        do_reset(8'hF3);
        write_read(1'b0, 1'b0, 16'h1A48, 16'h1A48, 32'h8765_4321, 32'h8765_4321);
        write_read(1'b0, 1'b0, 16'h1A4C, 16'h1A4C, 32'h0F1E_2D3C, 32'h0F1E_2D3C);
    endtask

    // Two single halfword writes, upper half first, still make one word write.
    task automatic sc_any_order();
        int w0;
        w0 = wr_cnt;
        cmd_single <= 1'b1;
        run_cmd(1'b1, 1'b0, 1'b0, 1'b0, 16'h1A52, 32'h5A5A_0000);
        run_cmd(1'b1, 1'b0, 1'b0, 1'b0, 16'h1A50, 32'h0000_A5A5);
        cmd_single <= 1'b0;
        chk(32'(wr_cnt - w0), 32'h1);
        chk({16'h0000, wr_addr}, 32'h0000_1A50);
        chk(wr_data, 32'h5A5A_A5A5);
    endtask

    // Big endian reverses the bytes of the word; a little endian read then sees them reversed.
    task automatic sc_narrow_big();
        do_reset(8'hF2);
        write_read(1'b0, 1'b1, 16'h0230, 16'h0230, 32'hA1B2_C3D4, 32'hD4C3_B2A1);
        rsp_seen = 'x;
        run_cmd(1'b0, 1'b0, 1'b0, 1'b0, 16'h0230, 32'h0000_0000);
        chk(rsp_seen, 32'hD4C3_B2A1);
        chk(mem[4'hC], 32'hD4C3_B2A1);
    endtask

    // A write with no low address phase must reuse the last latched address.
    task automatic sc_single_skip();
        int w0;
        do_reset(8'hF1);
        write_read(1'b0, 1'b0, 16'h5C20, 16'h5C20, 32'h1357_9BDF, 32'h1357_9BDF);
        w0 = wr_cnt;
        run_cmd(1'b1, 1'b0, 1'b1, 1'b0, 16'h0000, 32'h2468_ACE0);
        chk(32'(wr_cnt - w0), 32'h1);
        chk({16'h0000, wr_addr}, 32'h0000_5C20);
    endtask

    // Inverted pins, direction style, gated strobes; then the high address phase is left out.
    task automatic sc_style_qual();
        do_reset(8'h0F);
        write_read(1'b0, 1'b0, 16'h7E10, 16'h7E10, 32'hCAFE_0042, 32'hCAFE_0042);
        write_read(1'b1, 1'b0, 16'h0014, 16'h7E14, 32'h0BAD_F00D, 32'h0BAD_F00D);
    endtask

    initial begin
        for (int k = 0; k < 16; k++)
            mem[k] = 32'h0000_0000;
        sc_wide_dual();
        sc_any_order();
        sc_narrow_big();
        sc_single_skip();
        sc_style_qual();
        complete_run();
    end

    // A hang is cut short well after the 1300 or so cycles the scenarios need.
    initial begin
        repeat (30000) @(posedge clock);
        num_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
